// [include/plmec_pkg.sv]
// Package with register map, field positions, reset values and types for link and EEE control.
package plmec_pkg;
   localparam logic [15:0] ADDR_BASIC_LINK_CONTROL  = 16'h0000;
   localparam logic [15:0] ADDR_PHY_PAIR_CONTROL    = 16'h0019;
   localparam logic [15:0] ADDR_EEE_BYPASS_CONFIG   = 16'h04D1;
   localparam logic [15:0] ADDR_EEE_ADVERTISEMENT   = 16'h203C;
   localparam logic [15:0] ADDR_EEE_PARTNER_ABILITY = 16'h203D;
   localparam logic [15:0] ADDR_EEE_PCS_STATUS      = 16'h1001;
   localparam logic [15:0] ADDR_EEE_PCS_CAPABILITY  = 16'h1014;
   localparam logic [15:0] ADDR_EEE_WAKE_ERRORS     = 16'h1016;
   localparam logic [15:0] ADDR_LINK_STATUS         = 16'h0001;

   localparam int BLC_RESTART_BIT   = 9;
   localparam int BLC_AN_ENABLE_BIT = 12;
   localparam int BLC_SPEED_BIT     = 13;
   localparam int PPC_AUTO_SWAP_BIT = 15;
   localparam int PPC_FORCE_X_BIT   = 14;
   localparam int EBC_EN0_BIT       = 0;
   localparam int EBC_EN3_BIT       = 3;
   localparam int EBC_FORCE_LPI_BIT = 12;
   localparam int EADV_100_BIT      = 1;

   localparam logic [15:0] BLC_RESET  = 16'h2000;
   localparam logic [15:0] PPC_RESET  = 16'h8000;
   localparam logic [15:0] EBC_RESET  = 16'h0000;
   localparam logic [15:0] EADV_RESET = 16'h0000;

   localparam int CLK_HZ         = 10_000_000;
   localparam int PAIR_SETTLE_US = 1;
   localparam int PAIR_SETTLE_CYCLES = (PAIR_SETTLE_US * (CLK_HZ / 1_000_000));

   // Strap levels sampled once after power-on reset.
   typedef struct packed {
      logic enhanced_mode;
      logic an_enable;
      logic auto_swap;
      logic force_crossover;
      logic force_100;
      logic [4:0] mgmt_addr;
   } plmec_straps_s;

   // Ability word exchanged with the partner in fast link pulse bursts.
   typedef struct packed {
      logic can_100;
      logic can_10;
      logic eee_100;
      logic eee_10;
   } plmec_ability_s;

   typedef enum logic [2:0] {
      ST_DOWN     = 3'b000,
      ST_PAIR     = 3'b001,
      ST_BASEPAGE = 3'b010,
      ST_NEXTPG_F = 3'b011,
      ST_NEXTPG_U = 3'b100,
      ST_UP       = 3'b101
   } plmec_state_e;
endpackage : plmec_pkg

// [verilog/plmec_top.sv]
// Link mode, pair swap, negotiation and EEE control of a 10/100 transceiver.
`timescale 1ns/1ps
`default_nettype none
module plmec_top #(
   parameter int SETTLE_CYCLES = plmec_pkg::PAIR_SETTLE_CYCLES
) (
   input  wire  logic                     CORE_CLK,
   input  wire  logic                     NRST,
   input  wire  logic                     POR_N,
   input  wire  logic                     CRYSTAL_INPUT,
   input  wire  plmec_pkg::plmec_straps_s STRAPS,
   input  wire  logic                     POWER_DOWN_INPUT_N,
   input  wire  logic                     USER_RENEGOTIATE,
   input  wire  logic                     REG_WR,
   input  wire  logic                     REG_RD,
   input  wire  logic [15:0]              REG_ADDR,
   input  wire  logic [15:0]              REG_WDATA,
   output logic [15:0]                    REG_RDATA,
   output logic [4:0]                     MGMT_ADDR,
   input  wire  logic                     PAIR_ENERGY_STRAIGHT,
   input  wire  logic                     PAIR_ENERGY_CROSS,
   input  wire  logic                     PARTNER_PAGE_VALID,
   input  wire  plmec_pkg::plmec_ability_s PARTNER_ABILITY,
   input  wire  logic                     LINK_OK,
   output logic                           FLP_SEND,
   output logic [1:0]                     FLP_PAGE_KIND,
   output plmec_pkg::plmec_ability_s      FLP_ABILITY,
   output logic                           PAIR_CROSSOVER,
   output logic                           LINK_UP,
   output logic                           SPEED_100,
   output logic                           EEE_ACTIVE,
   output logic                           LPI_TX,
   output logic                           REFERENCE_CLOCK_OUTPUT
);
   plmec_pkg::plmec_state_e   state_q;
   plmec_pkg::plmec_state_e   state_d;
   plmec_pkg::plmec_straps_s  straps_q;
   plmec_pkg::plmec_ability_s partner_q;
   logic        straps_taken_q;
   logic        cfg_loaded_q;
   logic [15:0] blc_q;
   logic [15:0] ppc_q;
   logic [15:0] ebc_q;
   logic [15:0] eadv_q;
   logic        restart_pend_q;
   logic        link_was_q;
   logic        crossover_q;
   logic [15:0] settle_q;
   logic        an_on;
   logic        swap_auto;
   logic        eee_unbypassed;
   logic        local_eee;
   logic        partner_eee;
   logic        wr_hit_blc;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
      hit = (a == b);
   endfunction : hit

   assign wr_hit_blc = REG_WR && hit(REG_ADDR, plmec_pkg::ADDR_BASIC_LINK_CONTROL);
   assign an_on      = blc_q[plmec_pkg::BLC_AN_ENABLE_BIT];
   assign swap_auto  = ppc_q[plmec_pkg::PPC_AUTO_SWAP_BIT];

   // Straps are caught on the first clock after power-on release, never by the reset itself.
   always_ff @(posedge CORE_CLK or negedge POR_N) begin
      if (!POR_N) begin
         straps_q       <= '0;
         straps_taken_q <= 1'b0;
      end else if (!straps_taken_q) begin
         straps_q       <= STRAPS;
         straps_taken_q <= 1'b1;
      end
   end

   // In basic mode the address comes from fixed zero, as its pins carry MAC signals.
   assign MGMT_ADDR = straps_q.enhanced_mode ? straps_q.mgmt_addr : 5'h00;

   // The reference clock lives on the power-on reset only, so ordinary resets leave it running.
   always_ff @(posedge CORE_CLK or negedge POR_N) begin
      if (!POR_N) begin
         REFERENCE_CLOCK_OUTPUT <= 1'b0;
      end else begin
         REFERENCE_CLOCK_OUTPUT <= straps_q.enhanced_mode & CRYSTAL_INPUT;
      end
   end

   // Register writes; strap-derived defaults are reloaded after every reset, not only at power-on,
   // so a plain reset brings the link up with the strapped configuration as well.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         blc_q        <= plmec_pkg::BLC_RESET;
         ppc_q        <= plmec_pkg::PPC_RESET;
         ebc_q        <= plmec_pkg::EBC_RESET;
         eadv_q       <= plmec_pkg::EADV_RESET;
         cfg_loaded_q <= 1'b0;
      end else if (!cfg_loaded_q) begin
         cfg_loaded_q <= 1'b1;
         if (!straps_taken_q) begin
            blc_q[plmec_pkg::BLC_AN_ENABLE_BIT] <= STRAPS.an_enable;
            blc_q[plmec_pkg::BLC_SPEED_BIT]     <= STRAPS.force_100;
            ppc_q[plmec_pkg::PPC_AUTO_SWAP_BIT] <= STRAPS.auto_swap;
            ppc_q[plmec_pkg::PPC_FORCE_X_BIT]   <= STRAPS.force_crossover;
         end else begin
            blc_q[plmec_pkg::BLC_AN_ENABLE_BIT] <= straps_q.an_enable;
            blc_q[plmec_pkg::BLC_SPEED_BIT]     <= straps_q.force_100;
            ppc_q[plmec_pkg::PPC_AUTO_SWAP_BIT] <= straps_q.auto_swap;
            ppc_q[plmec_pkg::PPC_FORCE_X_BIT]   <= straps_q.force_crossover;
         end
      end else if (REG_WR) begin
         if (wr_hit_blc) begin
            blc_q <= REG_WDATA & ~(16'h0001 << plmec_pkg::BLC_RESTART_BIT);
         end
         if (hit(REG_ADDR, plmec_pkg::ADDR_PHY_PAIR_CONTROL)) begin
            ppc_q <= REG_WDATA;
         end
         if (hit(REG_ADDR, plmec_pkg::ADDR_EEE_BYPASS_CONFIG)) begin
            ebc_q <= REG_WDATA;
         end
         if (hit(REG_ADDR, plmec_pkg::ADDR_EEE_ADVERTISEMENT)) begin
            eadv_q <= REG_WDATA;
         end
      end
   end

   // Restart request; a request arriving as the state machine starts is held, not lost.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         restart_pend_q <= 1'b1;
         link_was_q     <= 1'b0;
      end else begin
         link_was_q <= LINK_UP;
         if ((wr_hit_blc && REG_WDATA[plmec_pkg::BLC_RESTART_BIT])
             || USER_RENEGOTIATE || (link_was_q && !LINK_OK)) begin
            restart_pend_q <= 1'b1;
         end else if (state_q == plmec_pkg::ST_PAIR) begin
            restart_pend_q <= 1'b0;
         end
      end
   end

   assign eee_unbypassed = ebc_q[plmec_pkg::EBC_EN0_BIT] && ebc_q[plmec_pkg::EBC_EN3_BIT]
                           && eadv_q[plmec_pkg::EADV_100_BIT];
   assign local_eee   = eee_unbypassed;
   assign partner_eee = partner_q.eee_100 | partner_q.eee_10;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         plmec_pkg::ST_DOWN: begin
            // Link is held down while the power-down input is low.
            if (POWER_DOWN_INPUT_N && straps_taken_q && restart_pend_q) begin
               state_d = plmec_pkg::ST_PAIR;
            end
         end
         plmec_pkg::ST_PAIR: begin
            if (settle_q == 16'h0000) begin
               state_d = an_on ? plmec_pkg::ST_BASEPAGE : plmec_pkg::ST_UP;
            end
         end
         plmec_pkg::ST_BASEPAGE: begin
            if (PARTNER_PAGE_VALID) begin
               state_d = (local_eee && (PARTNER_ABILITY.eee_100 || PARTNER_ABILITY.eee_10))
                         ? plmec_pkg::ST_NEXTPG_F : plmec_pkg::ST_UP;
            end
         end
         plmec_pkg::ST_NEXTPG_F: begin
            if (PARTNER_PAGE_VALID) begin
               state_d = plmec_pkg::ST_NEXTPG_U;
            end
         end
         plmec_pkg::ST_NEXTPG_U: begin
            if (PARTNER_PAGE_VALID) begin
               state_d = plmec_pkg::ST_UP;
            end
         end
         plmec_pkg::ST_UP: begin
            if (!POWER_DOWN_INPUT_N || restart_pend_q || !LINK_OK) begin
               state_d = plmec_pkg::ST_DOWN;
            end
         end
         default: state_d = plmec_pkg::ST_DOWN;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         state_q <= plmec_pkg::ST_DOWN;
      end else begin
         state_q <= state_d;
      end
   end

   // Pair resolution: in automatic mode the pair that sees energy wins; it settles before FLPs.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         crossover_q <= 1'b0;
         settle_q    <= 16'h0000;
      end else if (state_q == plmec_pkg::ST_DOWN) begin
         settle_q <= SETTLE_CYCLES[15:0];
      end else if (state_q == plmec_pkg::ST_PAIR) begin
         if (settle_q != 16'h0000) begin
            settle_q <= settle_q - 16'h0001;
         end
         if (swap_auto) begin
            if (PAIR_ENERGY_CROSS && !PAIR_ENERGY_STRAIGHT) begin
               crossover_q <= 1'b1;
            end else if (PAIR_ENERGY_STRAIGHT) begin
               crossover_q <= 1'b0;
            end
         end else begin
            crossover_q <= ppc_q[plmec_pkg::PPC_FORCE_X_BIT];
         end
      end
   end
   assign PAIR_CROSSOVER = crossover_q;

   // Partner abilities captured from the base page; they decide speed and EEE.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         partner_q <= '0;
      end else if (state_q == plmec_pkg::ST_PAIR) begin
         partner_q <= '0;
      end else if (state_q == plmec_pkg::ST_BASEPAGE && PARTNER_PAGE_VALID) begin
         partner_q <= PARTNER_ABILITY;
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         LINK_UP    <= 1'b0;
         SPEED_100  <= 1'b0;
         EEE_ACTIVE <= 1'b0;
         LPI_TX     <= 1'b0;
      end else begin
         LINK_UP   <= (state_d == plmec_pkg::ST_UP);
         SPEED_100 <= an_on ? partner_q.can_100 : blc_q[plmec_pkg::BLC_SPEED_BIT];
         // Both ends must advertise, else every EEE function stays off.
         EEE_ACTIVE <= (state_q == plmec_pkg::ST_UP) && an_on && local_eee && partner_eee;
         // Forced idle signalling also needs the partner's consent, or the far end loses the link.
         LPI_TX     <= (state_q == plmec_pkg::ST_UP) && an_on && local_eee && partner_eee
                       && ebc_q[plmec_pkg::EBC_FORCE_LPI_BIT];
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         FLP_SEND      <= 1'b0;
         FLP_PAGE_KIND <= 2'h0;
         FLP_ABILITY   <= '0;
      end else begin
         FLP_SEND      <= (state_q == plmec_pkg::ST_BASEPAGE) || (state_q == plmec_pkg::ST_NEXTPG_F)
                          || (state_q == plmec_pkg::ST_NEXTPG_U);
         FLP_PAGE_KIND <= (state_q == plmec_pkg::ST_NEXTPG_F) ? 2'h1 :
                          (state_q == plmec_pkg::ST_NEXTPG_U) ? 2'h2 : 2'h0;
         FLP_ABILITY   <= '{can_100: 1'b1, can_10: 1'b1,
                            eee_100: local_eee, eee_10: local_eee};
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         REG_RDATA <= 16'h0000;
      end else if (REG_RD) begin
         unique case (REG_ADDR)
            plmec_pkg::ADDR_BASIC_LINK_CONTROL:  REG_RDATA <= blc_q;
            plmec_pkg::ADDR_LINK_STATUS:         REG_RDATA <= {13'h0000, LINK_UP, SPEED_100, crossover_q};
            plmec_pkg::ADDR_PHY_PAIR_CONTROL:    REG_RDATA <= ppc_q;
            plmec_pkg::ADDR_EEE_BYPASS_CONFIG:   REG_RDATA <= ebc_q;
            plmec_pkg::ADDR_EEE_ADVERTISEMENT:   REG_RDATA <= eadv_q;
            plmec_pkg::ADDR_EEE_PARTNER_ABILITY: REG_RDATA <= {14'h0000, partner_q.eee_100, 1'b0};
            plmec_pkg::ADDR_EEE_PCS_CAPABILITY:  REG_RDATA <= 16'h0006;
            plmec_pkg::ADDR_EEE_PCS_STATUS:      REG_RDATA <= {14'h0000, LPI_TX, EEE_ACTIVE};
            plmec_pkg::ADDR_EEE_WAKE_ERRORS:     REG_RDATA <= 16'h0000;
            default:                             REG_RDATA <= 16'h0000;
         endcase
      end
   end
endmodule : plmec_top
`default_nettype wire

// [bench/plmec_assertions.sv]
// Checker for register, negotiation and low-power-idle behaviour at the top ports.
`timescale 1ns/1ps
`default_nettype none
module plmec_assertions (
   input wire logic                     CORE_CLK,
   input wire logic                     NRST,
   input wire logic                     POR_N,
   input wire logic                     CRYSTAL_INPUT,
   input wire plmec_pkg::plmec_straps_s STRAPS,
   input wire logic                     REG_WR,
   input wire logic                     REG_RD,
   input wire logic [15:0]              REG_ADDR,
   input wire logic [15:0]              REG_WDATA,
   input wire logic [15:0]              REG_RDATA,
   input wire logic                     LINK_OK,
   input wire logic                     FLP_SEND,
   input wire logic [1:0]               FLP_PAGE_KIND,
   input wire logic                     PAIR_CROSSOVER,
   input wire logic                     LINK_UP,
   input wire logic                     EEE_ACTIVE,
   input wire logic                     LPI_TX,
   input wire logic                     REFERENCE_CLOCK_OUTPUT
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   sequence s_restart_wr;
      REG_WR && REG_ADDR == plmec_pkg::ADDR_BASIC_LINK_CONTROL && REG_WDATA[9];
   endsequence
   sequence s_lpi_off_wr;
      REG_WR && REG_ADDR == plmec_pkg::ADDR_EEE_BYPASS_CONFIG && !REG_WDATA[12];
   endsequence
   a_restart_reads_zero: assert property (REG_RD && REG_ADDR == 16'h0000 |=> !REG_RDATA[9])
      else $error("restart bit read back as one");
   a_unmapped_read_zero: assert property (REG_RD && !(REG_ADDR inside {16'h0000, 16'h0001,
      16'h0019, 16'h04D1, 16'h203C, 16'h203D, 16'h1001, 16'h1014, 16'h1016}) |=> REG_RDATA == 16'h0000)
      else $error("unmapped read returned data");
   a_pair_held_flp: assert property (FLP_SEND && $past(FLP_SEND) |-> $stable(PAIR_CROSSOVER))
      else $error("pair assignment changed during ability exchange");
   a_lpi_needs_eee: assert property ($rose(LPI_TX) |-> EEE_ACTIVE && LINK_UP)
      else $error("idle signalling without negotiated low power");
   a_next_page_order: assert property (FLP_SEND && FLP_PAGE_KIND == 2'h2 && $past(FLP_PAGE_KIND) != 2'h2
      |-> $past(FLP_PAGE_KIND) == 2'h1)
      else $error("unformatted page not preceded by formatted page");
   a_lpi_stop_write: assert property (s_lpi_off_wr |-> ##[1:2] !LPI_TX)
      else $error("idle signalling did not stop");
   a_restart_drops_link: assert property (s_restart_wr |-> ##[1:3] !LINK_UP)
      else $error("restart did not take the link down");
   a_link_loss_drop: assert property (LINK_UP && !LINK_OK |-> ##[1:2] !LINK_UP)
      else $error("link stayed up after line loss");
   a_refclk_runs: assert property (@(posedge CORE_CLK) disable iff (!POR_N)
      STRAPS.enhanced_mode && $past(POR_N, 3) && $changed(CRYSTAL_INPUT)
      |-> ##[1:2] $changed(REFERENCE_CLOCK_OUTPUT))
      else $error("reference clock output stalled");
endmodule : plmec_assertions
bind plmec_top plmec_assertions plmec_assertions_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .POR_N(POR_N),
   .CRYSTAL_INPUT(CRYSTAL_INPUT), .STRAPS(STRAPS), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .LINK_OK(LINK_OK),
   .FLP_SEND(FLP_SEND), .FLP_PAGE_KIND(FLP_PAGE_KIND), .PAIR_CROSSOVER(PAIR_CROSSOVER),
   .LINK_UP(LINK_UP), .EEE_ACTIVE(EEE_ACTIVE), .LPI_TX(LPI_TX),
   .REFERENCE_CLOCK_OUTPUT(REFERENCE_CLOCK_OUTPUT));
`default_nettype wire

// [bench/plmec_link_partner.sv]
// Remote link partner: line energy, link status and page answers.
`timescale 1ns/1ps
`default_nettype none
module plmec_link_partner (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  flp_send,
   input wire logic [1:0]            page_kind,
   input wire logic                  cable_cross,
   input wire logic                  connected,
   input wire logic                  can_100,
   input wire logic                  eee,
   input wire logic                  slow,
   output logic                      energy_straight,
   output logic                      energy_cross,
   output logic                      link_ok,
   output logic                      page_valid,
   output plmec_pkg::plmec_ability_s ability
);
   logic [7:0] wait_q;
   logic [1:0] kind_q;
   logic       done_q;
   assign energy_straight = connected && !cable_cross;
   assign energy_cross    = connected && cable_cross;
   assign link_ok         = connected;
   // Outside a page the ability word is scrambled so a design reading it late sees garbage.
   assign ability = page_valid ? {can_100, 1'b1, eee, eee} : ~{can_100, 1'b1, eee, eee};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q     <= 8'h00;
         kind_q     <= 2'h0;
         done_q     <= 1'b0;
         page_valid <= 1'b0;
      end else begin
         page_valid <= 1'b0;
         kind_q     <= page_kind;
         if (!flp_send || page_kind != kind_q) begin
            wait_q <= 8'h00;
            done_q <= 1'b0;
         end else if (!done_q && wait_q == (slow ? 8'h0C : 8'h01)) begin
            page_valid <= 1'b1;
            done_q     <= 1'b1;
         end else begin
            wait_q <= wait_q + 8'h01;
         end
      end
   end
endmodule : plmec_link_partner
`default_nettype wire

// [bench/tb_phy_link_mode_and_eee_control.sv]
// Self-checking testbench for link mode and low-power control.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module tb_phy_link_mode_and_eee_control;
   logic clk, nrst, por_n, xtal, pdn_n, user_reneg, reg_wr, reg_rd, cable_cross, connected;
   logic p100, peee, slow, e_st, e_cr, pvalid, link_ok, flp_send, pair_x, link_up, spd;
   logic eee_act, lpi, refclk;
   logic [15:0] reg_addr, reg_wdata, rdata;
   logic [4:0]  mgmt;
   logic [1:0]  kind;
   plmec_pkg::plmec_straps_s  straps;
   plmec_pkg::plmec_ability_s p_ability, flp_ability;
   int mismatches, check_count;
   logic [31:0] eee_seq [18] = '{32'h001F_8000, 32'h203C_0002, 32'h04D1_008B, 32'h04D3_4F12,
      32'h04DF_0180, 32'h033E_A681, 32'h033F_0003, 32'h0123_0800, 32'h031B_8848, 32'h0466_FE00,
      32'h04CF_261D, 32'h0416_1F30, 32'h04F5_2864, 32'h04E0_FFF2, 32'h031F_FE36, 32'h0308_0000,
      32'h04F4_0800, 32'h0000_3300};
   plmec_top #(.SETTLE_CYCLES(2)) plmec_top_i (.CORE_CLK(clk), .NRST(nrst), .POR_N(por_n),
      .CRYSTAL_INPUT(xtal), .STRAPS(straps), .POWER_DOWN_INPUT_N(pdn_n),
      .USER_RENEGOTIATE(user_reneg), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .MGMT_ADDR(mgmt), .PAIR_ENERGY_STRAIGHT(e_st),
      .PAIR_ENERGY_CROSS(e_cr), .PARTNER_PAGE_VALID(pvalid), .PARTNER_ABILITY(p_ability),
      .LINK_OK(link_ok), .FLP_SEND(flp_send), .FLP_PAGE_KIND(kind), .FLP_ABILITY(flp_ability),
      .PAIR_CROSSOVER(pair_x), .LINK_UP(link_up), .SPEED_100(spd), .EEE_ACTIVE(eee_act),
      .LPI_TX(lpi), .REFERENCE_CLOCK_OUTPUT(refclk));
   plmec_link_partner plmec_link_partner_i (.clk(clk), .rst_n(nrst), .flp_send(flp_send),
      .page_kind(kind), .cable_cross(cable_cross), .connected(connected), .can_100(p100),
      .eee(peee), .slow(slow), .energy_straight(e_st), .energy_cross(e_cr), .link_ok(link_ok),
      .page_valid(pvalid), .ability(p_ability));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      xtal = 1'b0;
      forever begin
         repeat (2) @(posedge clk);
         xtal <= ~xtal;
      end
   end
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 `CHK(rdata & m, e)
   endtask : rd_chk
   task automatic wait_link(input logic v);
      for (int i = 0; i < 600 && link_up !== v; i++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1 `CHK(link_up, v)
   endtask : wait_link
   task automatic renego(input logic [15:0] d);
      wr(plmec_pkg::ADDR_BASIC_LINK_CONTROL, d);
      wait_link(1'b0);
      wait_link(1'b1);
   endtask : renego
   task automatic lpi_chk(input logic [15:0] d, input logic e);
      wr(plmec_pkg::ADDR_EEE_BYPASS_CONFIG, d);
      repeat (3) @(posedge clk);
      #1 `CHK(lpi, e)
   endtask : lpi_chk
   task end_sim;
      $display("mismatches=%0d check_count=%0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_sim();
   end
   initial begin
      {nrst, por_n, pdn_n, user_reneg, reg_wr, reg_rd, cable_cross, slow} = 8'h00;
      {connected, p100, peee} = 3'b111;
      {reg_addr, reg_wdata} = 32'h0000_0000;
      straps = {1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 5'h0B};
      repeat (10) @(posedge clk);
      {nrst, por_n} <= 2'b11;
      repeat (2) @(posedge clk);
      rd_chk(plmec_pkg::ADDR_BASIC_LINK_CONTROL, 16'h1200, 16'h1000);
      rd_chk(plmec_pkg::ADDR_PHY_PAIR_CONTROL, 16'h8000, 16'h8000);
      rd_chk(plmec_pkg::ADDR_EEE_BYPASS_CONFIG, 16'hFFFF, plmec_pkg::EBC_RESET);
      rd_chk(plmec_pkg::ADDR_EEE_ADVERTISEMENT, 16'hFFFF, plmec_pkg::EADV_RESET);
      rd_chk(16'h0ABC, 16'hFFFF, 16'h0000);
      `CHK(mgmt, 5'h0B)
      repeat (30) @(posedge clk);
      `CHK(link_up, 1'b0)
      pdn_n <= 1'b1;
      wait_link(1'b1);
      `CHK({spd, pair_x, eee_act}, 3'b100)
      foreach (eee_seq[i]) wr(eee_seq[i][31:16], eee_seq[i][15:0]);
      rd_chk(plmec_pkg::ADDR_EEE_BYPASS_CONFIG, 16'hFFFF, 16'h008B);
      rd_chk(plmec_pkg::ADDR_BASIC_LINK_CONTROL, 16'h0200, 16'h0000);
      wait_link(1'b1);
      `CHK(eee_act, 1'b1)
      lpi_chk(16'h108B, 1'b1);
      lpi_chk(16'h008B, 1'b0);
      p100 <= 1'b0;
      slow <= 1'b1;
      renego(16'h1200);
      `CHK({spd, eee_act}, 2'b01)
      lpi_chk(16'h108B, 1'b1);
      lpi_chk(16'h008B, 1'b0);
      {p100, peee, slow} <= 3'b100;
      renego(16'h1200);
      `CHK({spd, eee_act}, 2'b10)
      lpi_chk(16'h108B, 1'b0);
      lpi_chk(16'h008B, 1'b0);
      wr(plmec_pkg::ADDR_PHY_PAIR_CONTROL, 16'h4000);
      renego(16'h1200);
      `CHK(pair_x, 1'b1)
      cable_cross <= 1'b1;
      wr(plmec_pkg::ADDR_PHY_PAIR_CONTROL, 16'h8000);
      renego(16'h1200);
      `CHK(pair_x, 1'b1)
      renego(16'h2200);
      `CHK({pair_x, spd}, 2'b11)
      connected <= 1'b0;
      wait_link(1'b0);
      connected <= 1'b1;
      wait_link(1'b1);
      user_reneg <= 1'b1;
      @(posedge clk);
      user_reneg <= 1'b0;
      wait_link(1'b0);
      wait_link(1'b1);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(mgmt, 5'h0B)
      rd_chk(plmec_pkg::ADDR_BASIC_LINK_CONTROL, 16'h1000, 16'h1000);
      wait_link(1'b1);
      end_sim();
   end
endmodule : tb_phy_link_mode_and_eee_control
`default_nettype wire
